//--- hdl/sdf_pkg.sv
// shared constants and types of the stereo dac digital front end
package sdf_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 10;
  localparam int ANALOG_US = 20;
  localparam int ANALOG_CYC = (ANALOG_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int MCLK_STOP_NS = 1000;
  localparam int MCLK_STOP_CYC = MCLK_STOP_NS / CLK_NS;
  localparam int LRCK_STOP_US = 200;
  localparam int LRCK_STOP_DEF = LRCK_STOP_US * 1000 / CLK_NS;

  // ****************************************
  // audio
  // ****************************************
  localparam int WORD_BITS = 24;
  localparam int ZERO_FRAMES = 8192;
  localparam int WAKE_LRCK = 2;
  localparam int HOLD_NORMAL = 1024 / 16;
  localparam int HOLD_DOUBLE = 1024 / 8;
  localparam int HOLD_QUAD = 1024 / 4;
  localparam logic [12:0] GAIN_FULL = 13'h1000;
  localparam logic [12:0] STEP_NORMAL = 13'h0004;
  localparam logic [12:0] STEP_DOUBLE = 13'h0002;
  localparam logic [12:0] STEP_QUAD = 13'h0001;
  localparam int RATIO_NORMAL_MIN = 448;
  localparam int RATIO_DOUBLE_MIN = 224;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_LEFT = 5'h08;
  localparam logic [4:0] REG_RIGHT = 5'h0C;
  localparam int CTRL_MUTE_BIT = 0;
  localparam logic CTRL_RESET = 1'h0;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_ANALOG_BIT = 1;
  localparam int STAT_SPEED_LSB = 2;
  localparam int STAT_ZERO_BIT = 4;
  localparam int STAT_MUTE_BIT = 5;
  localparam int STAT_GAIN_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SPD_NORMAL, SPD_DOUBLE, SPD_QUAD} sdf_speed_t;
  typedef enum logic [1:0] {ST_DOWN, ST_WAKE, ST_HOLD, ST_RUN} sdf_state_t;

endpackage

//--- hdl/sdf_sync.sv
// two flip-flop synchroniser for pins from outside the clk_sys domain
`timescale 1ns/100ps
module sdf_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // meta_reg is read by q alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

//--- hdl/sdf_serial_rx.sv
// serial audio word receiver, msb-justified or i2s framing
`timescale 1ns/100ps
module sdf_serial_rx import sdf_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // synchronised link
  input wire logic bick_rise,
  input wire logic lrck,
  input wire logic sdata,
  input wire logic fmt,
  // received words
  output logic signed [23:0] left_word,
  output logic signed [23:0] right_word,
  output logic frame_stb
);

  logic lr_last_reg;
  logic [4:0] pos_reg;
  logic [4:0] pos;
  logic [4:0] bits_reg;
  logic chan_left_reg;
  logic [22:0] shift_reg;
  logic [4:0] first_pos;

  // bit position since the last frame clock edge; i2s starts one bit late
  assign pos = (lrck != lr_last_reg) ? 5'h00 : pos_reg;
  assign first_pos = fmt ? 5'h01 : 5'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lr_last_reg <= 1'b0;
      pos_reg <= 5'h1F;
      bits_reg <= 5'h18;
      chan_left_reg <= 1'b0;
      shift_reg <= 23'h000000;
      left_word <= 24'h000000;
      right_word <= 24'h000000;
      frame_stb <= 1'b0;
    end else begin
      frame_stb <= 1'b0;
      if (bick_rise) begin
        lr_last_reg <= lrck;
        pos_reg <= (pos == 5'h1F) ? pos : pos + 5'h01;
        // the first bit of an i2s word lands one bit after the frame clock edge
        if (pos == first_pos) begin
          bits_reg <= 5'h01;
          shift_reg <= {22'h000000, sdata};
          chan_left_reg <= lrck ^ fmt;
        end else if (bits_reg < 5'(WORD_BITS)) begin
          bits_reg <= bits_reg + 5'h01;
          shift_reg <= {shift_reg[21:0], sdata};
          if (bits_reg == 5'(WORD_BITS - 1)) begin
            if (chan_left_reg) begin
              left_word <= {shift_reg, sdata};
            end else begin
              right_word <= {shift_reg, sdata};
              frame_stb <= 1'b1;
            end
          end
        end
      end
    end
  end

endmodule

//--- hdl/sdf_dac_top.sv
// digital front end of a stereo 24-bit dac with an axi4-lite register port
`timescale 1ns/100ps

module sdf_dac_top import sdf_pkg::*; #(
  parameter int LRCK_STOP_CYC = LRCK_STOP_DEF
) (
  // system
  input wire logic clk_sys,
  input wire logic nrst,
  // audio link pins
  input wire logic mclk,
  input wire logic bick,
  input wire logic lrck,
  input wire logic serial_sample_in,
  input wire logic format_select,
  input wire logic soft_mute_request,
  // converter side
  output logic signed [23:0] left_output,
  output logic signed [23:0] right_output,
  output logic sample_strobe,
  output logic zero_flag,
  output logic analog_on,
  // axi4-lite write
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [12:0] ramp_step(input sdf_speed_t s);
    unique case (s)
      SPD_NORMAL: ramp_step = STEP_NORMAL;
      SPD_DOUBLE: ramp_step = STEP_DOUBLE;
      SPD_QUAD: ramp_step = STEP_QUAD;
      default: ramp_step = STEP_QUAD;
    endcase
  endfunction

  // gain is 1.12 fixed point; product keeps the sign of the sample
  function automatic logic signed [23:0] scale(input logic signed [23:0] s, input logic [12:0] g);
    logic signed [37:0] p;
    p = s * $signed({1'b0, g});
    scale = p[35:12];
  endfunction

  function automatic logic addr_mapped(input logic [4:0] a);
    addr_mapped = (a[4] == 1'b0);
  endfunction

  // ****************************************
  // reset release and pin capture
  // ****************************************
  logic [1:0] rst_pipe_reg;
  logic rst_n;
  logic mclk_s, bick_s, lrck_s, sdata_s, fmt_s, soft_mute_request_s;
  logic mclk_d, bick_d, lrck_d;
  logic mclk_rise, bick_rise, lrck_rise;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_reg[1];

  sdf_sync #(.W(6)) u_sync (
    .clk(clk_sys),
    .rst_n(rst_n),
    .d({mclk, bick, lrck, serial_sample_in, format_select, soft_mute_request}),
    .q({mclk_s, bick_s, lrck_s, sdata_s, fmt_s, soft_mute_request_s})
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mclk_d <= 1'b0;
      bick_d <= 1'b0;
      lrck_d <= 1'b0;
    end else begin
      mclk_d <= mclk_s;
      bick_d <= bick_s;
      lrck_d <= lrck_s;
    end
  end
  assign mclk_rise = mclk_s & ~mclk_d;
  assign bick_rise = bick_s & ~bick_d;
  assign lrck_rise = lrck_s & ~lrck_d;

  // ****************************************
  // serial receiver
  // ****************************************
  logic signed [23:0] rx_left, rx_right;
  logic frame_stb;

  sdf_serial_rx u_rx (
    .clk(clk_sys),
    .rst_n(rst_n),
    .bick_rise(bick_rise),
    .lrck(lrck_s),
    .sdata(sdata_s),
    .fmt(fmt_s),
    .left_word(rx_left),
    .right_word(rx_right),
    .frame_stb(frame_stb)
  );

  // ****************************************
  // clock activity and speed
  // ****************************************
  logic [7:0] mclk_idle_reg;
  logic mclk_ok_reg;
  logic [23:0] lrck_idle_reg;
  logic lrck_ok_reg;
  logic clk_ok;
  logic [10:0] ratio_reg;
  sdf_speed_t speed_reg;

  // mclk above half the sampling rate aliases; the bench keeps it slow enough
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mclk_idle_reg <= 8'h00;
      mclk_ok_reg <= 1'b0;
    end else if (mclk_rise) begin
      mclk_idle_reg <= 8'h00;
      mclk_ok_reg <= 1'b1;
    end else if (mclk_idle_reg == 8'(MCLK_STOP_CYC - 1)) begin
      mclk_ok_reg <= 1'b0;
    end else begin
      mclk_idle_reg <= mclk_idle_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lrck_idle_reg <= 24'h000000;
      lrck_ok_reg <= 1'b0;
    end else if (lrck_rise) begin
      lrck_idle_reg <= 24'h000000;
      lrck_ok_reg <= 1'b1;
    end else if (lrck_idle_reg == 24'(LRCK_STOP_CYC - 1)) begin
      lrck_ok_reg <= 1'b0;
    end else begin
      lrck_idle_reg <= lrck_idle_reg + 24'h000001;
    end
  end
  assign clk_ok = mclk_ok_reg & lrck_ok_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ratio_reg <= 11'h000;
      speed_reg <= SPD_NORMAL;
    end else if (lrck_rise) begin
      ratio_reg <= mclk_rise ? 11'h001 : 11'h000;
      if (ratio_reg >= 11'(RATIO_NORMAL_MIN)) begin
        speed_reg <= SPD_NORMAL;
      end else if (ratio_reg >= 11'(RATIO_DOUBLE_MIN)) begin
        speed_reg <= SPD_DOUBLE;
      end else begin
        speed_reg <= SPD_QUAD;
      end
    end else if (mclk_rise && ratio_reg != 11'h7FF) begin
      ratio_reg <= ratio_reg + 11'h001;
    end
  end

  // ****************************************
  // power sequencer
  // ****************************************
  sdf_state_t st_reg;
  logic [11:0] tmr_reg;
  logic [8:0] lcnt_reg;
  logic [8:0] hold_len;

  always_comb begin
    unique case (speed_reg)
      SPD_NORMAL: hold_len = 9'(HOLD_NORMAL);
      SPD_DOUBLE: hold_len = 9'(HOLD_DOUBLE);
      SPD_QUAD: hold_len = 9'(HOLD_QUAD);
      default: hold_len = 9'(HOLD_QUAD);
    endcase
  end

  // the sequence restarts from the top whenever mclk or lrck goes missing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_DOWN;
      tmr_reg <= 12'h000;
      lcnt_reg <= 9'h000;
      analog_on <= 1'b0;
    end else if (!clk_ok) begin
      st_reg <= ST_DOWN;
      tmr_reg <= 12'h000;
      lcnt_reg <= 9'h000;
      analog_on <= 1'b0;
    end else begin
      unique case (st_reg)
        ST_DOWN: begin
          st_reg <= ST_WAKE;
        end
        ST_WAKE: begin
          if (tmr_reg != 12'(ANALOG_CYC)) begin
            tmr_reg <= tmr_reg + 12'h001;
          end else begin
            analog_on <= 1'b1;
          end
          if (lrck_rise && lcnt_reg != 9'(WAKE_LRCK)) begin
            lcnt_reg <= lcnt_reg + 9'h001;
          end
          if (analog_on && lcnt_reg == 9'(WAKE_LRCK)) begin
            st_reg <= ST_HOLD;
            lcnt_reg <= 9'h000;
          end
        end
        ST_HOLD: begin
          if (lcnt_reg == hold_len) begin
            st_reg <= ST_RUN;
          end else if (lrck_rise) begin
            lcnt_reg <= lcnt_reg + 9'h001;
          end
        end
        ST_RUN: begin
        end
      endcase
    end
  end

  // ****************************************
  // soft mute ramp
  // ****************************************
  logic ctrl_mute_reg;
  logic mute_req;
  logic [12:0] gain_reg;
  logic [12:0] step;

  assign mute_req = soft_mute_request_s | ctrl_mute_reg;
  assign step = ramp_step(speed_reg);

  // a release mid-ramp simply reverses direction from the present gain
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gain_reg <= GAIN_FULL;
    end else if (st_reg != ST_RUN) begin
      gain_reg <= mute_req ? 13'h0000 : GAIN_FULL;
    end else if (frame_stb) begin
      if (mute_req) begin
        gain_reg <= (gain_reg > step) ? gain_reg - step : 13'h0000;
      end else if (gain_reg + step >= GAIN_FULL) begin
        gain_reg <= GAIN_FULL;
      end else begin
        gain_reg <= gain_reg + step;
      end
    end
  end

  // ****************************************
  // zero detect and outputs
  // ****************************************
  logic [13:0] zcnt_reg;
  logic both_zero;

  assign both_zero = (rx_left == 24'h000000) && (rx_right == 24'h000000);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      zcnt_reg <= 14'h0000;
    end else if (st_reg != ST_RUN || (frame_stb && !both_zero)) begin
      zcnt_reg <= 14'h0000;
    end else if (frame_stb && zcnt_reg != 14'(ZERO_FRAMES)) begin
      zcnt_reg <= zcnt_reg + 14'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      zero_flag <= 1'b0;
    end else if (st_reg != ST_RUN) begin
      zero_flag <= 1'b0;
    end else if (frame_stb && !both_zero) begin
      zero_flag <= 1'b0;
    end else if (zcnt_reg == 14'(ZERO_FRAMES)) begin
      zero_flag <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      left_output <= 24'h000000;
      right_output <= 24'h000000;
      sample_strobe <= 1'b0;
    end else if (st_reg != ST_RUN) begin
      left_output <= 24'h000000;
      right_output <= 24'h000000;
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= frame_stb;
      if (frame_stb) begin
        left_output <= scale(rx_left, gain_reg);
        right_output <= scale(rx_right, gain_reg);
      end
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic [4:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_got_reg, w_got_reg;
  logic wr_fire;
  logic [31:0] rd_word;

  assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 5'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
        aw_got_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
        w_got_reg <= 1'b1;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // only the control word is writable; the rest ignore writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_mute_reg <= CTRL_RESET;
    end else if (wr_fire && {awaddr_reg[4:2], 2'h0} == REG_CTRL && wstrb_reg[0]) begin
      ctrl_mute_reg <= wdata_reg[CTRL_MUTE_BIT];
    end
  end

  always_comb begin
    rd_word = 32'h00000000;
    unique case ({s_axi_araddr[4:2], 2'h0})
      REG_CTRL: rd_word[CTRL_MUTE_BIT] = ctrl_mute_reg;
      REG_STATUS: begin
        rd_word[STAT_RUN_BIT] = (st_reg == ST_RUN);
        rd_word[STAT_ANALOG_BIT] = analog_on;
        rd_word[STAT_SPEED_LSB +: 2] = speed_reg;
        rd_word[STAT_ZERO_BIT] = zero_flag;
        rd_word[STAT_MUTE_BIT] = mute_req;
        rd_word[STAT_GAIN_LSB +: 13] = gain_reg;
      end
      REG_LEFT: rd_word = {8'h00, left_output};
      REG_RIGHT: rd_word = {8'h00, right_output};
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_zero_low_down: assert property ((st_reg != ST_RUN) |=> !zero_flag)
    else $error("zero flag high outside run");
  a_zero_set_count: assert property ($rose(zero_flag) |-> $past(zcnt_reg) == 14'(ZERO_FRAMES))
    else $error("zero flag rose before 8192 zero frames");
  a_zero_drop_now: assert property ((st_reg == ST_RUN && frame_stb && !both_zero) |=> !zero_flag)
    else $error("zero flag not dropped on nonzero data");
  a_mute_ramp_down: assert property ((st_reg == ST_RUN && frame_stb && mute_req && gain_reg >= step)
    |=> gain_reg == $past(gain_reg) - $past(step))
    else $error("mute ramp step wrong");
  a_unmute_ramp_up: assert property ((st_reg == ST_RUN && frame_stb && !mute_req && gain_reg + step <= GAIN_FULL)
    |=> gain_reg == $past(gain_reg) + $past(step))
    else $error("unmute ramp step wrong");
  a_release_turns: assert property ((st_reg == ST_RUN && $fell(mute_req)) |-> ##1 gain_reg >= $past(gain_reg))
    else $error("gain dropped after release");
  a_down_waits: assert property ((st_reg == ST_DOWN && !lrck_ok_reg) |=> st_reg == ST_DOWN)
    else $error("left power down without frame clock");
  a_analog_delay: assert property ($rose(analog_on) |-> $past(tmr_reg) == 12'(ANALOG_CYC))
    else $error("analog on at wrong time");
  a_digital_wake: assert property ($rose(st_reg == ST_HOLD) |-> $past(lcnt_reg) == 9'(WAKE_LRCK))
    else $error("digital wake after wrong frame count");
  a_hold_frames: assert property ($rose(st_reg == ST_RUN) |-> $past(lcnt_reg) == $past(hold_len))
    else $error("output hold length wrong");
  a_stop_grounds: assert property (!clk_ok |=> st_reg == ST_DOWN ##1 (left_output == 24'h000000
    && right_output == 24'h000000))
    else $error("outputs not grounded after clock stop");
  a_restart_wake: assert property ((st_reg == ST_DOWN && clk_ok) |=> st_reg == ST_WAKE)
    else $error("no restart with clocks back");
  a_speed_normal: assert property ((lrck_rise && ratio_reg >= 11'(RATIO_NORMAL_MIN)) |=> speed_reg == SPD_NORMAL)
    else $error("normal speed not detected");

  c_run_reached: cover property ($rose(st_reg == ST_RUN));
  c_zero_raised: cover property ($rose(zero_flag));
  c_mute_bottom: cover property (st_reg == ST_RUN && gain_reg == 13'h0000);
  c_restart: cover property ($fell(clk_ok) ##[1:1000] $rose(st_reg == ST_WAKE));

endmodule

//--- verif/sdf_audio_src.sv
// behavioural serial audio source for the dac front end
`timescale 1ns/100ps
module sdf_audio_src (
  // bench control
  input wire logic en,
  input wire logic i2s,
  input wire logic [23:0] left_word,
  input wire logic [23:0] right_word,
  // link pins
  output logic mclk,
  output logic bick,
  output logic lrck,
  output logic sdata
);
  // ********
  // clocks
  // ********
  // 24 ns against 72 bits a frame gives 480 master clocks per frame, normal speed
  initial begin
    mclk = 1'b0;
    forever begin
      #12;
      mclk = en & ~mclk;
    end
  end
  // a frame is always finished, then bick and lrck stand still until enabled; mclk stops at once
  initial begin : gen
    logic fmt;
    logic [23:0] w;
    int pos;
    bick = 1'b0;
    lrck = 1'b0;
    sdata = 1'b0;
    forever begin
      wait (en);
      fmt = i2s;
      for (int h = 0; h < 2; h++) begin
        w = (h == 0) ? left_word : right_word;
        for (int k = 0; k < 36; k++) begin
          pos = fmt ? k - 1 : k;
          bick = 1'b0;
          lrck = (h == 0) ^ fmt;
          // idle bits toggle so a stale value never looks valid
          sdata = (pos >= 0 && pos < 24) ? w[23 - pos] : ~sdata;
          #80;
          bick = 1'b1;
          #80;
        end
      end
    end
  end
endmodule

//--- verif/tb_top.sv
// self-checking bench of the stereo dac front end
`timescale 1ns/100ps
module tb_top import sdf_pkg::*; ;
  logic clk_sys, nrst, en, fmt, mute, awvalid, wvalid, bready, arvalid, rready, mclk, bick, lrck, sdata;
  logic awready, wready, bvalid, arready, rvalid, strobe, zero_flag, analog_on;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, g;
  logic [1:0] bresp, rresp, r;
  logic [23:0] lw, rw;
  logic signed [23:0] lo, ro;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int t;
  sdf_audio_src sdf_audio_src_inst (.en(en), .i2s(fmt), .left_word(lw), .right_word(rw), .mclk(mclk),
    .bick(bick), .lrck(lrck), .sdata(sdata));
  // short frame-clock timeout keeps the stop test quick; still above one frame
  sdf_dac_top #(.LRCK_STOP_CYC(2000)) sdf_dac_top_inst (.clk_sys(clk_sys), .nrst(nrst), .mclk(mclk),
    .bick(bick), .lrck(lrck), .serial_sample_in(sdata), .format_select(fmt), .soft_mute_request(mute),
    .left_output(lo), .right_output(ro), .sample_strobe(strobe), .zero_flag(zero_flag), .analog_on(analog_on),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  // ********
  // tasks
  // ********
  task automatic give_verdict();
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [4:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic frames(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      while (strobe !== 1'b1) @(negedge clk_sys);
    end
    @(posedge clk_sys);
  endtask
  // ********
  // clock, watchdog and tests
  // ********
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 105000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    {nrst, en, fmt, mute, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, lw, rw} = '0;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(REG_STATUS);
    chk(d, {3'h0, GAIN_FULL, 16'h0000});
    rd(5'h10);
    chk(r, RESP_SLVERR);
    wr(5'h14, 32'h1);
    chk(r, RESP_SLVERR);
    lw <= 24'h800000;
    rw <= 24'h123456;
    en <= 1'b1;
    t = cyc;
    while (analog_on !== 1'b1) @(posedge clk_sys);
    chk(cyc - t >= ANALOG_CYC && cyc - t <= ANALOG_CYC + 20, 1);
    t = cyc;
    frames(1);
    chk(cyc - t >= 62 * 1152 && cyc - t <= 68 * 1152, 1);
    chk({8'h00, lo}, 32'h0080_0000);
    chk({8'h00, ro}, 32'h0012_3456);
    rd(REG_STATUS);
    chk(d, 32'h1000_0003);
    fmt <= 1'b1;
    lw <= 24'h7FFFFF;
    rw <= 24'h000001;
    // the first i2s frame has no left edge, so only its right word lands
    frames(2);
    chk({8'h00, lo}, 32'h007F_FFFF);
    chk({8'h00, ro}, 32'h0000_0001);
    mute <= 1'b1;
    frames(1);
    rd(REG_STATUS);
    g = d;
    frames(5);
    rd(REG_STATUS);
    chk(d[28:16], g[28:16] - 13'h0014);
    g = d;
    mute <= 1'b0;
    frames(5);
    rd(REG_STATUS);
    chk(d[28:16], g[28:16] + 13'h0014);
    wr(REG_CTRL, 32'h1);
    frames(1);
    rd(REG_STATUS);
    chk(d[5], 1'b1);
    wr(REG_CTRL, 32'h0);
    lw <= 24'h000000;
    rw <= 24'h000000;
    frames(1);
    chk({lo, zero_flag}, 25'h0);
    lw <= 24'h000400;
    frames(1);
    chk(zero_flag, 1'b0);
    lw <= 24'h000000;
    en <= 1'b0;
    t = cyc;
    while (lo !== 24'h0) @(posedge clk_sys);
    chk(cyc - t <= 120, 1);
    chk({analog_on, zero_flag}, 2'h0);
    en <= 1'b1;
    t = cyc;
    while (analog_on !== 1'b1) @(posedge clk_sys);
    chk(cyc - t <= ANALOG_CYC + 20, 1);
    give_verdict();
  end
endmodule
